// file: pfe_pkg.sv
// Constants and types for the program flash ECC checker.
package pfe_pkg;
    // Register indices; the byte address on the bus is four times the index.
    localparam logic [15:0] IDX_CFG = 16'ha00d;
    localparam logic [15:0] IDX_FA_LO = 16'ha00e;
    localparam logic [15:0] IDX_FA_HI = 16'ha00f;
    localparam logic [7:0] CFG_RST = 8'h80;
    localparam logic [15:0] FA_RST = 16'h8000;
    // Configuration bit positions.
    localparam int CFG_FCEN = 7;
    localparam int CFG_UIEN = 5;
    localparam int CFG_CIEN = 4;
    localparam int CFG_UF = 1;
    localparam int CFG_CF = 0;
    // Fault address bits at and above this position read as zero.
    localparam int FA_ZERO_LSB = 14;
    localparam int BYTE_W = 8;
    localparam int NIB_W = 4;
    // Syndromes that point at a data bit of a nibble.
    localparam logic [2:0] SYN_D0 = 3'h3;
    localparam logic [2:0] SYN_D1 = 3'h5;
    localparam logic [2:0] SYN_D2 = 3'h6;
    localparam logic [2:0] SYN_D3 = 3'h7;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] word;
    } pfe_fetch_t;

    typedef struct packed {
        logic fc_en;
        logic uirq_en;
        logic cirq_en;
        logic uflag;
        logic cflag;
    } pfe_cfg_t;

    typedef struct packed {
        logic [3:0] data;
        logic corr;
        logic uncorr;
    } pfe_nib_t;
endpackage

// file: pfe_checker.sv
// Program flash ECC checker with an AXI4-Lite register slave.
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Flash word: low byte data, high byte check.
// - Check [15:12] guards [7:4], [11:8] guards [3:0].
// - Per nibble: fix one error, detect two.
// - Fetch checked concurrently; corrected byte delivered.
// - Uncorrectable fetch: interrupt or software reset.
// - Any fetch error latches fault address.
// - Config bit 7 selects corrected controller reads.
// - Config bit 5 enables uncorrectable interrupt.
// - Config bit 4 enables correctable interrupt.
// - Uncorrectable flag bit 1 sticky until cleared.
// - Correctable flag bit 0 sticky until cleared.
// - Fault address read-only, always latest error.
// - Fault address bits 15:14 read zero.
module pfe_checker
    import pfe_pkg::*;
#(
    parameter int ADDR_W = 18
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic fetch_valid,
    input wire pfe_fetch_t fetch_in,
    output logic [7:0] fetch_byte_r,
    output logic fetch_byte_valid_r,
    input wire logic fc_valid,
    input wire logic [15:0] fc_word,
    output logic [15:0] fc_rdata_r,
    output logic fc_rdata_valid_r,
    output logic irq_corr,
    output logic irq_uncorr,
    output logic soft_reset_req_r
);
    localparam logic [ADDR_W-1:0] A_CFG = ADDR_W'({IDX_CFG, 2'h0});
    localparam logic [ADDR_W-1:0] A_LO = ADDR_W'({IDX_FA_LO, 2'h0});
    localparam logic [ADDR_W-1:0] A_HI = ADDR_W'({IDX_FA_HI, 2'h0});

    // Extended Hamming code on one nibble: check bits 0..2 are parities,
    // bit 3 is the overall parity, so a double error leaves parity even.
    function automatic pfe_nib_t nib_dec(input logic [3:0] d, input logic [3:0] c);
        logic [2:0] s;
        logic p;
        pfe_nib_t r;
        s[0] = c[0] ^ d[0] ^ d[1] ^ d[3];
        s[1] = c[1] ^ d[0] ^ d[2] ^ d[3];
        s[2] = c[2] ^ d[1] ^ d[2] ^ d[3];
        p = ^{c, d};
        r.data = d;
        r.corr = p;
        r.uncorr = !p && (s != 3'h0);
        if (p) begin
            unique case (s)
                SYN_D0: r.data[0] = !d[0];
                SYN_D1: r.data[1] = !d[1];
                SYN_D2: r.data[2] = !d[2];
                SYN_D3: r.data[3] = !d[3];
                default: r.data = d;
            endcase
        end
        return r;
    endfunction

    pfe_nib_t fnib [2];
    pfe_nib_t cnib [2];
    logic [7:0] fetch_fix;
    logic [7:0] fc_fix;
    logic corr_ev;
    logic uncorr_ev;

    for (genvar g = 0; g < 2; g++) begin : g_nib
        always_comb begin
            fnib[g] = nib_dec(fetch_in.word[g*NIB_W +: NIB_W],
                fetch_in.word[BYTE_W + g*NIB_W +: NIB_W]);
            cnib[g] = nib_dec(fc_word[g*NIB_W +: NIB_W],
                fc_word[BYTE_W + g*NIB_W +: NIB_W]);
        end
    end

    always_comb begin
        fetch_fix = {fnib[1].data, fnib[0].data};
        fc_fix = {cnib[1].data, cnib[0].data};
        // A double error in either nibble makes the whole fetch uncorrectable.
        uncorr_ev = fetch_valid && (fnib[0].uncorr || fnib[1].uncorr);
        corr_ev = fetch_valid && !uncorr_ev && (fnib[0].corr || fnib[1].corr);
    end

    // Configuration state is read by the datapath, so it is declared ahead of both groups.
    pfe_cfg_t cfg_r, cfg_nxt;

    // Datapath group.
    logic [7:0] fetch_byte_nxt;
    logic fetch_byte_valid_nxt;
    logic [15:0] fc_rdata_nxt;
    logic fc_rdata_valid_nxt;
    logic soft_reset_req_nxt;

    always_comb begin
        fetch_byte_nxt = fetch_byte_r;
        fc_rdata_nxt = fc_rdata_r;
        if (fetch_valid) begin
            fetch_byte_nxt = fetch_fix;
        end
        if (fc_valid) begin
            fc_rdata_nxt = cfg_r.fc_en ? {fc_word[15:8], fc_fix} : fc_word;
        end
        fetch_byte_valid_nxt = fetch_valid;
        fc_rdata_valid_nxt = fc_valid;
        // Reset request is a one-cycle pulse; the reset controller stretches it.
        soft_reset_req_nxt = uncorr_ev && !cfg_r.uirq_en;
    end

    // Register and bus group.
    logic [15:0] fault_addr_r, fault_addr_nxt;
    logic aw_hold_r, aw_hold_nxt;
    logic w_hold_r, w_hold_nxt;
    logic [ADDR_W-1:0] awaddr_r, awaddr_nxt;
    logic [31:0] wdata_r, wdata_nxt;
    logic [3:0] wstrb_r, wstrb_nxt;
    logic bvalid_r, bvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt;
    logic rvalid_r, rvalid_nxt;
    logic [1:0] rresp_r, rresp_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic aw_ok, w_ok, wr_go;
    logic cflag_clr;
    logic [ADDR_W-1:0] wa;
    logic [31:0] wd;
    logic [3:0] ws;

    always_comb begin
        awready = !aw_hold_r && !bvalid_r;
        wready = !w_hold_r && !bvalid_r;
        arready = !rvalid_r;
        aw_ok = aw_hold_r || (awvalid && awready);
        w_ok = w_hold_r || (wvalid && wready);
        wr_go = aw_ok && w_ok;
        wa = aw_hold_r ? awaddr_r : awaddr;
        wd = w_hold_r ? wdata_r : wdata;
        ws = w_hold_r ? wstrb_r : wstrb;
        cflag_clr = wr_go && (wa == A_CFG) && ws[0] && !wd[CFG_CF];

        cfg_nxt = cfg_r;
        fault_addr_nxt = fault_addr_r;
        aw_hold_nxt = aw_hold_r;
        w_hold_nxt = w_hold_r;
        awaddr_nxt = awaddr_r;
        wdata_nxt = wdata_r;
        wstrb_nxt = wstrb_r;
        bvalid_nxt = bvalid_r && !bready;
        bresp_nxt = bresp_r;
        rvalid_nxt = rvalid_r && !rready;
        rresp_nxt = rresp_r;
        rdata_nxt = rdata_r;

        if (wr_go) begin
            aw_hold_nxt = 1'b0;
            w_hold_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = RESP_OKAY;
            // Fault address registers accept and ignore writes.
            if (wa == A_CFG) begin
                if (ws[0]) begin
                    cfg_nxt.fc_en = wd[CFG_FCEN];
                    cfg_nxt.uirq_en = wd[CFG_UIEN];
                    cfg_nxt.cirq_en = wd[CFG_CIEN];
                    // Writing one to a flag leaves it alone.
                    cfg_nxt.uflag = cfg_r.uflag && wd[CFG_UF];
                    cfg_nxt.cflag = cfg_r.cflag && wd[CFG_CF];
                end
            end else if (wa != A_LO && wa != A_HI) begin
                bresp_nxt = RESP_DECERR;
            end
        end else begin
            if (awvalid && awready) begin
                aw_hold_nxt = 1'b1;
                awaddr_nxt = awaddr;
            end
            if (wvalid && wready) begin
                w_hold_nxt = 1'b1;
                wdata_nxt = wdata;
                wstrb_nxt = wstrb;
            end
        end

        // Hardware sets after the software clear, so a same-cycle event wins.
        if (uncorr_ev) begin
            cfg_nxt.uflag = 1'b1;
        end
        if (corr_ev) begin
            cfg_nxt.cflag = 1'b1;
        end
        if (uncorr_ev || corr_ev) begin
            fault_addr_nxt = fetch_in.addr;
        end

        if (arvalid && arready) begin
            rvalid_nxt = 1'b1;
            rresp_nxt = RESP_OKAY;
            rdata_nxt = 32'h0;
            if (araddr == A_CFG) begin
                rdata_nxt[CFG_FCEN] = cfg_r.fc_en;
                rdata_nxt[CFG_UIEN] = cfg_r.uirq_en;
                rdata_nxt[CFG_CIEN] = cfg_r.cirq_en;
                rdata_nxt[CFG_UF] = cfg_r.uflag;
                rdata_nxt[CFG_CF] = cfg_r.cflag;
            end else if (araddr == A_LO) begin
                rdata_nxt[7:0] = fault_addr_r[7:0];
            end else if (araddr == A_HI) begin
                rdata_nxt[FA_ZERO_LSB-BYTE_W-1:0] =
                    fault_addr_r[FA_ZERO_LSB-1:BYTE_W];
            end else begin
                rresp_nxt = RESP_DECERR;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fetch_byte_r <= 8'h0;
            fetch_byte_valid_r <= 1'b0;
            fc_rdata_r <= 16'h0;
            fc_rdata_valid_r <= 1'b0;
            soft_reset_req_r <= 1'b0;
            cfg_r <= pfe_cfg_t'({CFG_RST[CFG_FCEN], CFG_RST[CFG_UIEN],
                CFG_RST[CFG_CIEN], CFG_RST[CFG_UF], CFG_RST[CFG_CF]});
            fault_addr_r <= FA_RST;
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= 32'h0;
            wstrb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
            rvalid_r <= 1'b0;
            rresp_r <= RESP_OKAY;
            rdata_r <= 32'h0;
        end else begin
            fetch_byte_r <= fetch_byte_nxt;
            fetch_byte_valid_r <= fetch_byte_valid_nxt;
            fc_rdata_r <= fc_rdata_nxt;
            fc_rdata_valid_r <= fc_rdata_valid_nxt;
            soft_reset_req_r <= soft_reset_req_nxt;
            cfg_r <= cfg_nxt;
            fault_addr_r <= fault_addr_nxt;
            aw_hold_r <= aw_hold_nxt;
            w_hold_r <= w_hold_nxt;
            awaddr_r <= awaddr_nxt;
            wdata_r <= wdata_nxt;
            wstrb_r <= wstrb_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rresp_r <= rresp_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    always_comb begin
        bvalid = bvalid_r;
        bresp = bresp_r;
        rvalid = rvalid_r;
        rresp = rresp_r;
        rdata = rdata_r;
        irq_corr = cfg_r.cflag && cfg_r.cirq_en;
        irq_uncorr = cfg_r.uflag && cfg_r.uirq_en;
    end

    default clocking dc @(posedge aclk); endclocking
    default disable iff (!aresetn);

    clean_pass_a: assert property (
        fetch_valid && !fnib[0].corr && !fnib[1].corr && !uncorr_ev
        |=> fetch_byte_r == $past(fetch_in.word[7:0]) && fetch_byte_valid_r)
        else $error("clean fetch byte altered");
    corr_flag_a: assert property (
        corr_ev |=> cfg_r.cflag ##1 (cfg_r.cflag || $past(cflag_clr)))
        else $error("correctable flag not set and held");
    uncorr_flag_a: assert property (uncorr_ev |=> cfg_r.uflag)
        else $error("uncorrectable flag not set");
    reset_pulse_a: assert property (
        uncorr_ev && !cfg_r.uirq_en |=> soft_reset_req_r && !irq_uncorr)
        else $error("soft reset not requested");
    no_reset_a: assert property (
        uncorr_ev && cfg_r.uirq_en |=> !soft_reset_req_r ##0 irq_uncorr)
        else $error("interrupt path not taken");
    fault_addr_a: assert property (
        uncorr_ev || corr_ev |=> fault_addr_r == $past(fetch_in.addr))
        else $error("fault address not captured");
    hi_zero_a: assert property (
        arvalid && arready && araddr == A_HI
        |=> rvalid && rdata[7:0] == {2'h0, $past(fault_addr_r[13:8])})
        else $error("fault address top bits not zero");
    raw_read_a: assert property (
        fc_valid && !cfg_r.fc_en |=> fc_rdata_r == $past(fc_word))
        else $error("raw controller read altered");
    flag_clear_a: assert property (
        cflag_clr && !corr_ev
        |=> !cfg_r.cflag && !irq_corr)
        else $error("correctable flag not cleared");
endmodule // pfe_checker
`default_nettype wire

// file: pfe_flash_model.sv
// Behavioural flash and fetch-side model that feeds words to the ECC checker.
`timescale 1ns/1ps
`default_nettype none
module pfe_flash_model
    import pfe_pkg::*;
(
    input wire logic aclk,
    output logic fetch_valid,
    output pfe_fetch_t fetch_in,
    output logic fc_valid,
    output logic [15:0] fc_word
);
    logic [15:0] last_w;

    function automatic logic [3:0] enc(input logic [3:0] d);
        logic [2:0] c;
        c = {d[1] ^ d[2] ^ d[3], d[0] ^ d[2] ^ d[3], d[0] ^ d[1] ^ d[3]};
        return {^{d, c}, c};
    endfunction

    initial begin
        fetch_valid = 1'b0;
        fc_valid = 1'b0;
        fetch_in = '0;
        fc_word = '0;
        last_w = '0;
    end

    // Released lines show the inverted word, so stale data can never pass for a fresh one.
    task automatic send(input logic [15:0] a, input logic [7:0] d, input logic [15:0] flip,
                        input logic fc);
        @(posedge aclk);
        last_w = {enc(d[7:4]), enc(d[3:0]), d} ^ flip;
        fetch_valid <= !fc;
        fc_valid <= fc;
        fetch_in <= {a, last_w};
        fc_word <= last_w;
        @(posedge aclk);
        fetch_valid <= 1'b0;
        fc_valid <= 1'b0;
        fetch_in <= ~{a, last_w};
        fc_word <= ~last_w;
    endtask
endmodule // pfe_flash_model
`default_nettype wire

// file: pfe_checker_tb.sv
// Self-checking testbench for the program flash ECC checker.
`timescale 1ns/1ps
`default_nettype none
module pfe_checker_tb
    import pfe_pkg::*;
;
    localparam logic [17:0] A_CFG = {IDX_CFG, 2'b00};
    localparam logic [17:0] A_LO = {IDX_FA_LO, 2'b00};
    localparam logic [17:0] A_HI = {IDX_FA_HI, 2'b00};
    localparam logic [17:0] A_BAD = 18'h28040;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, fetch_valid, fetch_byte_valid_r;
    logic fc_valid, fc_rdata_valid_r, irq_corr, irq_uncorr, soft_reset_req_r;
    logic [17:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd_v;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rsp;
    logic [7:0] fetch_byte_r;
    logic [15:0] fc_word, fc_rdata_r;
    pfe_fetch_t fetch_in;
    int errors, checks, cyc;

    pfe_checker #(.ADDR_W(18)) pfe_checker_i (.aclk, .aresetn, .awaddr, .awvalid, .awready,
        .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
        .arready, .rdata, .rresp, .rvalid, .rready, .fetch_valid, .fetch_in, .fetch_byte_r,
        .fetch_byte_valid_r, .fc_valid, .fc_word, .fc_rdata_r, .fc_rdata_valid_r, .irq_corr,
        .irq_uncorr, .soft_reset_req_r);
    pfe_flash_model pfe_flash_model_i (.aclk, .fetch_valid, .fetch_in, .fc_valid, .fc_word);

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks = checks + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // The whole run needs well under a thousand cycles; a hang is cut off here.
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors = errors + 1;
            end_sim();
        end
    end

    task automatic wr(input logic [17:0] a, input logic [7:0] d);
        logic aw_ok;
        logic w_ok;
        @(posedge aclk);
        aw_ok = 1'b0;
        w_ok = 1'b0;
        awaddr <= a;
        wdata <= {24'h0, d};
        wstrb <= 4'h1;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (!aw_ok && awready) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        while (!bvalid) @(posedge aclk);
        rsp = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [17:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        rd_v = rdata;
        rsp = rresp;
        rready <= 1'b0;
    endtask

    // One fetch, then the delivered byte, interrupt lines, flags and fault address.
    task automatic fchk(input logic [15:0] a, input logic [7:0] d, input logic [15:0] flip,
                        input logic unc, input logic sr, input logic [7:0] cfg);
        pfe_flash_model_i.send(a, d, flip, 1'b0);
        #1;
        chk(fetch_byte_valid_r, 1);
        if (!unc) begin
            chk(fetch_byte_r, d);
        end
        chk(soft_reset_req_r, sr);
        chk(irq_corr, cfg[0] & cfg[4]);
        chk(irq_uncorr, cfg[1] & cfg[5]);
        rd(A_CFG);
        chk(rd_v, cfg);
        if (flip != 16'h0) begin
            rd(A_LO);
            chk(rd_v, a[7:0]);
            rd(A_HI);
            chk(rd_v, a[13:8]);
        end
    endtask

    initial begin
        errors = 0;
        checks = 0;
        cyc = 0;
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, wstrb} = '0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        rd(A_CFG);
        chk(rd_v, CFG_RST);
        rd(A_HI);
        chk(rd_v, 0);
        rd(A_BAD);
        chk(rsp, RESP_DECERR);
        wr(A_BAD, 8'h00);
        chk(rsp, RESP_DECERR);
        wr(A_LO, 8'hff);
        rd(A_LO);
        chk(rd_v, 0);
        fchk(16'h0100, 8'h5a, 16'h0, 0, 0, 8'h80);
        wr(A_CFG, 8'h90);
        for (int i = 0; i < 16; i++) begin
            fchk(16'hc000 + 16'(i) * 16'h0101, 8'ha5 ^ 8'(i), 16'h1 << i, 0, 0, 8'h91);
            wr(A_CFG, 8'h90);
            rd(A_CFG);
            chk(rd_v, 8'h90);
            chk(irq_corr, 0);
        end
        fchk(16'h3fff, 8'h3c, 16'h0011, 0, 0, 8'h91);
        wr(A_CFG, 8'h20);
        fchk(16'h1234, 8'h0f, 16'h0003, 1, 0, 8'h22);
        fchk(16'h0200, 8'h11, 16'h0, 0, 0, 8'h22);
        wr(A_CFG, 8'h80);
        fchk(16'h4321, 8'hf0, 16'h0300, 1, 1, 8'h82);
        wr(A_CFG, 8'h80);
        pfe_flash_model_i.send(16'h0, 8'h96, 16'h0010, 1'b1);
        #1;
        chk(fc_rdata_valid_r, 1);
        chk(fc_rdata_r, {pfe_flash_model_i.last_w[15:8], 8'h96});
        wr(A_CFG, 8'h00);
        pfe_flash_model_i.send(16'h0, 8'h96, 16'h0010, 1'b1);
        #1;
        chk(fc_rdata_r, pfe_flash_model_i.last_w);
        rd(A_CFG);
        chk(rd_v, 8'h00);
        end_sim();
    end
endmodule // pfe_checker_tb
`default_nettype wire
